// ==== inc/cmd_pkg.sv ====
// constants for the global-update write and power-control command decoder
// assumes a bus front end that delivers one whole three-byte write at a time
package cmd_pkg;
    localparam int CHANNELS = 8;
    localparam int CODE_W = 12;
    // command and access nibble values
    localparam logic [3:0] CMD_WRITE_UPDATE_ALL = 4'h2;
    localparam logic [3:0] CMD_POWER_CONTROL = 4'h4;
    localparam logic [3:0] ACCESS_BROADCAST = 4'hF;
    // field positions in the 24-bit frame
    localparam int CMD_HI = 23;
    localparam int CMD_LO = 20;
    localparam int ACC_HI = 19;
    localparam int ACC_LO = 16;
    localparam int CODE_HI = 15;
    localparam int CODE_LO = 4;
    localparam int PMODE_HI = 14;
    localparam int PMODE_LO = 13;
    localparam int MASK_HI = 12;
    localparam int MASK_LO = 5;
    // power modes
    localparam logic [1:0] PMODE_ON = 2'h0;
    localparam logic [1:0] PMODE_1K = 2'h1;
    localparam logic [1:0] PMODE_100K = 2'h2;
    localparam logic [1:0] PMODE_HIZ = 2'h3;
    // reset values
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam logic [15:0] POWER_RESET = 16'h0000;
    localparam logic [7:0] ON_RESET = 8'hFF;
endpackage

// ==== inc/cmd_if.sv ====
// decoded command carried from the decoder to the main datapath
// assumes a single clock domain
`timescale 1ns/1ps
interface cmd_if;
    logic wr_en;
    logic [7:0] wr_sel;
    logic [11:0] code;
    logic pwr_en;
    logic [7:0] pwr_mask;
    logic [1:0] pwr_mode;
    modport dec (output wr_en, wr_sel, code, pwr_en, pwr_mask, pwr_mode);
    modport core (input wr_en, wr_sel, code, pwr_en, pwr_mask, pwr_mode);
endinterface

// ==== logic/cmd_decode.sv ====
// combinational decode of one 24-bit write frame
// assumes frame and its valid come from the bus front end
`timescale 1ns/1ps
module cmd_decode (
    // frame in
    input wire logic frame_valid,
    input wire logic [23:0] frame,
    // decoded command
    cmd_if.dec c
);
    wire [3:0] cmd = frame[cmd_pkg::CMD_HI:cmd_pkg::CMD_LO];
    wire [3:0] acc = frame[cmd_pkg::ACC_HI:cmd_pkg::ACC_LO];
    wire access_nibble_top_bit = acc[3];
    wire is_bcast = (acc == cmd_pkg::ACCESS_BROADCAST);
    wire is_wr = frame_valid && (cmd == cmd_pkg::CMD_WRITE_UPDATE_ALL);
    assign c.wr_en = is_wr && (!access_nibble_top_bit || is_bcast);
    assign c.wr_sel = is_bcast ? 8'hFF : (8'h01 << acc[2:0]);
    assign c.code = frame[cmd_pkg::CODE_HI:cmd_pkg::CODE_LO];
    assign c.pwr_en = frame_valid && (cmd == cmd_pkg::CMD_POWER_CONTROL);
    assign c.pwr_mask = frame[cmd_pkg::MASK_HI:cmd_pkg::MASK_LO];
    assign c.pwr_mode = frame[cmd_pkg::PMODE_HI:cmd_pkg::PMODE_LO];
endmodule

// ==== logic/dac_cmd_update_powerdown.sv ====
// top of the command decoder: input, output and power state registers
// assumes FRAME_VALID pulses once per complete three-byte write, REF_CLK 40 MHz
`timescale 1ns/1ps
// Notes on behaviour
// - code sits in DB15..DB4, low nibble ignored
// - channel write then load all outputs
// - top access bit set, not broadcast: ignore
// - broadcast writes every input, loads all
// - power command: mode DB14:13, mask DB12..5
// - mode 00 powers on masked channels
// - mode 01 powers down, 1k to ground
// - mode 10 powers down, 100k to ground
// - mode 11 powers down, output high impedance
module dac_cmd_update_powerdown (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RSTN,
    // write frame from the serial front end
    input wire logic FRAME_VALID,
    input wire logic [23:0] FRAME,
    // channel outputs, channel A in the low slot
    output logic [95:0] OUT_CODE,
    output logic [7:0] OUTPUT_LOAD_STROBE,
    // power state, two bits per channel, 00 means on
    output logic [15:0] CHANNEL_POWER_CONTROL,
    output logic [7:0] CHANNEL_ON
);
    // ========================================
    // decode
    cmd_if c ();
    cmd_decode cmd_decode_i (
        .frame_valid(FRAME_VALID),
        .frame(FRAME),
        .c(c)
    );

    // ========================================
    // input registers and output registers
    logic [11:0] in_r [8];
    logic [11:0] in_nxt [8];
    logic load_nxt;
    logic [15:0] pwr_nxt;
    logic [7:0] on_nxt;

    always_comb
    begin
        load_nxt = c.wr_en;
        for (int i = 0; i < 8; i++)
        begin
            in_nxt[i] = (c.wr_en && c.wr_sel[i]) ? c.code : in_r[i];
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RSTN)
        begin
            for (int i = 0; i < 8; i++)
                in_r[i] <= cmd_pkg::CODE_RESET;
            OUT_CODE <= {8{cmd_pkg::CODE_RESET}};
            OUTPUT_LOAD_STROBE <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                in_r[i] <= in_nxt[i];
                if (load_nxt)
                    OUT_CODE[i*12 +: 12] <= in_nxt[i];
            end
            OUTPUT_LOAD_STROBE <= {8{load_nxt}};
        end
    end

    // ========================================
    // power state
    always_comb
    begin
        pwr_nxt = CHANNEL_POWER_CONTROL;
        on_nxt = CHANNEL_ON;
        for (int i = 0; i < 8; i++)
        begin
            if (c.pwr_en && c.pwr_mask[i])
            begin
                pwr_nxt[2*i +: 2] = c.pwr_mode;
                on_nxt[i] = (c.pwr_mode == cmd_pkg::PMODE_ON);
            end
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RSTN)
        begin
            CHANNEL_POWER_CONTROL <= cmd_pkg::POWER_RESET;
            CHANNEL_ON <= cmd_pkg::ON_RESET;
        end
        else
        begin
            CHANNEL_POWER_CONTROL <= pwr_nxt;
            CHANNEL_ON <= on_nxt;
        end
    end

    // ========================================
    // checks
    // frame fields as the rules place them, read by the checks only
    wire [3:0] cmd_seen = FRAME[cmd_pkg::CMD_HI:cmd_pkg::CMD_LO];
    wire [3:0] acc_seen = FRAME[cmd_pkg::ACC_HI:cmd_pkg::ACC_LO];
    wire [11:0] code_seen = FRAME[cmd_pkg::CODE_HI:cmd_pkg::CODE_LO];
    wire [1:0] mode_seen = FRAME[cmd_pkg::PMODE_HI:cmd_pkg::PMODE_LO];
    wire [7:0] mask_seen = FRAME[cmd_pkg::MASK_HI:cmd_pkg::MASK_LO];
    wire bcast_seen = (acc_seen == cmd_pkg::ACCESS_BROADCAST);
    wire pwr_seen = FRAME_VALID && (cmd_seen == cmd_pkg::CMD_POWER_CONTROL);
    // a write the rules accept: one of channels A..H, or broadcast
    wire load_seen = FRAME_VALID && (cmd_seen == cmd_pkg::CMD_WRITE_UPDATE_ALL)
        && (!acc_seen[3] || bcast_seen);

    // a channel counts as on only while its mode field reads on
    function automatic logic [7:0] on_of_modes(input logic [15:0] modes);
        logic [7:0] ons;
        ons = 8'h00;
        for (int i = 0; i < cmd_pkg::CHANNELS; i++)
        begin
            ons[i] = (modes[2*i +: 2] == cmd_pkg::PMODE_ON);
        end
        return ons;
    endfunction

    sequence s_write_all;
        FRAME_VALID && cmd_seen == cmd_pkg::CMD_WRITE_UPDATE_ALL;
    endsequence

    sequence s_power_cmd;
        pwr_seen;
    endsequence

    a_invalid_access_ignored: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        s_write_all and (acc_seen[3] && !bcast_seen)
        |=> OUTPUT_LOAD_STROBE == 8'h00 && $stable(OUT_CODE))
        else $error("invalid access changed outputs");

    a_bcast_loads_all: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        s_write_all and bcast_seen
        |=> OUT_CODE == {8{$past(code_seen)}})
        else $error("broadcast did not load all");

    a_channel_write_load: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        s_write_all and !acc_seen[3]
        |=> OUTPUT_LOAD_STROBE == 8'hFF
            && OUT_CODE[$past(acc_seen[2:0])*cmd_pkg::CODE_W +: 12] == $past(code_seen))
        else $error("channel write not loaded");

    a_code_field: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        s_write_all and bcast_seen
        |=> OUT_CODE[11:4] == $past(FRAME[15:8]) && OUT_CODE[3:0] == $past(FRAME[7:4]))
        else $error("code field misplaced");

    a_strobe_all_bits: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        load_seen
        |=> OUTPUT_LOAD_STROBE == 8'hFF)
        else $error("load strobe not raised on every channel");

    a_strobe_only_load: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        !load_seen
        |=> OUTPUT_LOAD_STROBE == 8'h00)
        else $error("load strobe without accepted write");

    a_power_on_mode: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        s_power_cmd and mode_seen == cmd_pkg::PMODE_ON
        |=> (CHANNEL_ON & $past(mask_seen)) == $past(mask_seen))
        else $error("power on missed");

    a_on_matches_mode: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        CHANNEL_ON == on_of_modes(CHANNEL_POWER_CONTROL))
        else $error("channel on flags disagree with modes");

    a_power_down_mode: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        s_power_cmd and mode_seen != cmd_pkg::PMODE_ON
        |=> (CHANNEL_ON & $past(mask_seen)) == 8'h00)
        else $error("power down missed");

    a_pull_1k_stored: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        s_power_cmd and mode_seen == cmd_pkg::PMODE_1K && mask_seen[1]
        |=> CHANNEL_POWER_CONTROL[3:2] == cmd_pkg::PMODE_1K && !CHANNEL_ON[1])
        else $error("1k termination not stored");

    a_pull_100k_stored: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        s_power_cmd and mode_seen == cmd_pkg::PMODE_100K && mask_seen[2]
        |=> CHANNEL_POWER_CONTROL[5:4] == cmd_pkg::PMODE_100K && !CHANNEL_ON[2])
        else $error("100k termination not stored");

    a_mode_stored: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        s_power_cmd and mask_seen[0]
        |=> CHANNEL_POWER_CONTROL[1:0] == $past(mode_seen))
        else $error("power mode not stored");

    a_hiz_stored: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        s_power_cmd and mode_seen == cmd_pkg::PMODE_HIZ && mask_seen[7]
        |=> CHANNEL_POWER_CONTROL[15:14] == cmd_pkg::PMODE_HIZ)
        else $error("high impedance not stored");

    a_unmasked_kept: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        s_power_cmd and !mask_seen[0]
        |=> $stable(CHANNEL_POWER_CONTROL[1:0]))
        else $error("unmasked channel changed");

    a_access_ignored: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        s_power_cmd and acc_seen[3] && mask_seen[0]
        |=> CHANNEL_POWER_CONTROL[1:0] == $past(mode_seen))
        else $error("access nibble affected power command");
endmodule

// ==== test/frame_host.sv ====
// model of the bus controller: hands over whole three-byte write frames
// assumes the decoder samples on the rising edge of clk
`timescale 1ns/1ps
module frame_host (
    // clock
    input wire logic clk,
    // frame out
    output logic valid,
    output logic [23:0] frame
);
    // ==========
    // driver
    initial
    begin
        valid = 1'b0;
        frame = 24'h000000;
    end
    task automatic send(input logic [23:0] f);
    begin
        @(negedge clk);
        valid = 1'b1;
        frame = f;
        @(negedge clk);
        valid = 1'b0;
        // released bus shows no stale frame
        frame = ~f;
    end
    endtask
    // two frames on consecutive edges, no idle cycle between
    task automatic send_pair(input logic [23:0] f0, input logic [23:0] f1);
    begin
        @(negedge clk);
        valid = 1'b1;
        frame = f0;
        @(negedge clk);
        frame = f1;
        @(negedge clk);
        valid = 1'b0;
        frame = ~f1;
    end
    endtask
endmodule

// ==== test/dac_cmd_update_powerdown_tb.sv ====
// self-checking bench for the command decoder
// assumes frame_host drives the frame inputs
`timescale 1ns/1ps
module dac_cmd_update_powerdown_tb;
    logic ref_clk, rstn, fv;
    logic [23:0] fr;
    logic [95:0] code;
    logic [7:0] strobe, on;
    logic [15:0] pwr;
    logic [7:0][11:0] exp_code;
    logic [7:0][1:0] exp_pwr;
    logic [7:0] exp_on;
    int bad_count, checked, cycles;
    dac_cmd_update_powerdown dac_cmd_update_powerdown_i (.REF_CLK(ref_clk), .RSTN(rstn),
        .FRAME_VALID(fv), .FRAME(fr), .OUT_CODE(code), .OUTPUT_LOAD_STROBE(strobe),
        .CHANNEL_POWER_CONTROL(pwr), .CHANNEL_ON(on));
    frame_host frame_host_i (.clk(ref_clk), .valid(fv), .frame(fr));
    // ==========
    // clock and timeout
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            bad_count++;
            end_of_test();
        end
    end
    // ==========
    // checks
    task automatic cmp(input logic ok, input string m);
    begin
        checked++;
        if (!ok)
        begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    end
    endtask
    task automatic cmp_state;
    begin
        for (int i = 0; i < 8; i++)
            exp_on[i] = (exp_pwr[i] == 2'h0);
        cmp(code === exp_code, "output codes");
        cmp(pwr === exp_pwr, "power modes");
        cmp(on === exp_on, "channel on");
    end
    endtask
    task automatic end_of_test;
    begin
        $display("checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    // ==========
    // scenarios
    task automatic t_write;
    begin
        frame_host_i.send(24'h23ABC5);
        exp_code[3] = 12'hABC;
        cmp_state();
        cmp(strobe === 8'hFF, "load strobe");
        frame_host_i.send(24'h27FED0);
        exp_code[7] = 12'hFED;
        cmp_state();
    end
    endtask
    task automatic t_bcast;
    begin
        frame_host_i.send(24'h2F1230);
        exp_code = {8{12'h123}};
        cmp_state();
        cmp(strobe === 8'hFF, "broadcast strobe");
        @(negedge ref_clk);
        cmp(strobe === 8'h00, "strobe one cycle");
    end
    endtask
    task automatic t_refuse;
    begin
        frame_host_i.send(24'h295550);
        cmp_state();
        cmp(strobe === 8'h00, "refused strobe");
        frame_host_i.send(24'h2E7770);
        cmp_state();
        cmp(strobe === 8'h00, "refused strobe again");
    end
    endtask
    task automatic t_back;
    begin
        frame_host_i.send_pair(24'h204560, {8'h40, 1'b0, 2'h1, 8'h80, 5'h00});
        exp_code[0] = 12'h456;
        exp_pwr[7] = 2'h1;
        cmp_state();
        cmp(strobe === 8'h00, "strobe after power command");
    end
    endtask
    task automatic t_reset;
    begin
        @(negedge ref_clk);
        rstn = 1'b0;
        @(negedge ref_clk);
        rstn = 1'b1;
        exp_code = '0;
        exp_pwr = '0;
        cmp_state();
        cmp(strobe === 8'h00, "strobe after reset");
    end
    endtask
    task automatic t_power(input logic [1:0] m, input logic [7:0] mask);
    begin
        frame_host_i.send({8'h4A, 1'b0, m, mask, 5'h00});
        for (int i = 0; i < 8; i++)
            if (mask[i])
                exp_pwr[i] = m;
        cmp_state();
    end
    endtask
    initial
    begin
        rstn = 1'b0;
        exp_code = '0;
        exp_pwr = '0;
        repeat (10) @(negedge ref_clk);
        rstn = 1'b1;
        cmp_state();
        t_write();
        t_bcast();
        t_refuse();
        t_power(2'h1, 8'h03);
        t_power(2'h2, 8'h0C);
        t_power(2'h3, 8'hC1);
        t_power(2'h0, 8'h05);
        t_back();
        t_reset();
        end_of_test();
    end
endmodule
